// ### inc/tmrps_map.svh
/*
 * Register offsets, field positions, reset values and counter widths of the
 * eight-bit timer with its shared prescaler.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef TMRPS_MAP_SVH
`define TMRPS_MAP_SVH

// Register byte addresses on the plain register port
`define TMRPS_ADDR_W 4
`define TMRPS_OFS_COUNT 4'h0
`define TMRPS_OFS_OPTION 4'h1
`define TMRPS_OFS_INTCTL 4'h2
`define TMRPS_OFS_STATUS 4'h3
`define TMRPS_OFS_CLEAR 4'h4
`define TMRPS_OFS_ENABLE 4'h5
`define TMRPS_OFS_CTRL 4'h6
`define TMRPS_OFS_WDOG 4'h7

// Option register fields
`define TMRPS_OPT_RATIO_LSB 0
`define TMRPS_OPT_RATIO_MSB 2
`define TMRPS_OPT_PSA 3
`define TMRPS_OPT_SRC 5
`define TMRPS_OPT_EDGE 4
`define TMRPS_OPT_RESET 8'hFF

// Interrupt control register fields
`define TMRPS_IC_FLAG 2
`define TMRPS_IC_IE 5
`define TMRPS_IC_GIE 7
`define TMRPS_IC_RESET 8'h00
`define TMRPS_IC_MASK 8'hA4

// Event status bits
`define TMRPS_EV_OVF 0
`define TMRPS_EV_WDTO 1
`define TMRPS_EV_W 2

// Control register fields
`define TMRPS_CTL_SLEEP 0
`define TMRPS_CTL_WCLR 1

// Counter widths and reset values
`define TMRPS_PS_W 8
`define TMRPS_PS_ZERO 8'h00
`define TMRPS_CNT_ZERO 8'h00
`define TMRPS_CNT_ONES 8'hFF
`define TMRPS_DATA_ZERO 8'h00

`endif

// ### inc/tmrps_pkg.sv
/*
 * Types shared by the timer modules.
 * Assumes tmrps_map.svh is on the include path.
 */
package tmrps_pkg;
	`include "tmrps_map.svh"

	// Prescaler owner
	typedef enum logic {
		TMRPS_OWN_TIMER = 1'b0,
		TMRPS_OWN_WDOG = 1'b1
	} tmrps_owner_t;

	// Four internal phases of one instruction cycle
	typedef enum logic [3:0] {
		TMRPS_Q1 = 4'h1,
		TMRPS_Q2 = 4'h2,
		TMRPS_Q3 = 4'h4,
		TMRPS_Q4 = 4'h8
	} tmrps_phase_t;
endpackage

// ### inc/tmrps_ps_if.sv
/*
 * Carrier between the timer core and its shared prescaler.
 * Assumes one clock domain; the core drives the controls.
 */
`timescale 1ns/100ps
interface tmrps_ps_if;
	logic tick_in;
	logic clear;
	logic [2:0] ratio;
	logic owner_wdog;
	logic ps_out;
	modport core (output tick_in, output clear, output ratio,
		output owner_wdog, input ps_out);
	modport ps (input tick_in, input clear, input ratio,
		input owner_wdog, output ps_out);
endinterface

// ### hw/tmrps_prescaler.sv
/*
 * The single shared prescaler: a ripple-style count of input ticks whose
 * selected bit falling gives one output pulse.
 * Assumes ticks are one-cycle pulses from the owner's clock path.
 */
`timescale 1ns/100ps
`include "tmrps_map.svh"
module tmrps_prescaler
	import tmrps_pkg::*;
#(
	parameter int PS_W = `TMRPS_PS_W
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	tmrps_ps_if.ps bus
);
	logic [PS_W-1:0] cnt_reg;
	logic [PS_W-1:0] cnt_next;
	logic fire;

	// Code n fires as bit n falls, every 2^(n+1)-th tick; a rising bit
	// would fire after only half the ratio following a clear
	assign cnt_next = cnt_reg + {{(PS_W-1){1'b0}}, 1'b1};
	assign fire = bus.tick_in
		&& (cnt_reg[bus.ratio] && !cnt_next[bus.ratio]); // [R16] [R3]

	// Count is internal only; clear from counter write or watchdog clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_reg <= `TMRPS_PS_ZERO;
		end else if (bus.clear) begin
			cnt_reg <= `TMRPS_PS_ZERO; // [R5] [R6] [R7]
		end else if (bus.tick_in) begin
			cnt_reg <= cnt_next;
		end
	end

	// One output pulse per full division
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus.ps_out <= 1'b0;
		end else begin
			bus.ps_out <= fire && !bus.clear; // [R1]
		end
	end
endmodule

// ### hw/tmrps_phase.sv
/*
 * Four-phase sequencer standing in for the instruction-cycle clock phases,
 * with the two-stage sampling of the counter-mode tick on Q2 and Q4.
 * Assumes the external clock input is already synchronous to i_clk.
 */
`timescale 1ns/100ps
module tmrps_phase
	import tmrps_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_src,
	output logic o_sync,
	output logic o_q4
);
	tmrps_phase_t ph_reg;
	logic smp2_reg;
	logic smp4_reg;

	// Phase rotation Q1 to Q4
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_reg <= TMRPS_Q1;
		end else begin
			unique case (ph_reg)
				TMRPS_Q1: ph_reg <= TMRPS_Q2;
				TMRPS_Q2: ph_reg <= TMRPS_Q3;
				TMRPS_Q3: ph_reg <= TMRPS_Q4;
				TMRPS_Q4: ph_reg <= TMRPS_Q1;
			endcase
		end
	end

	// Sample on Q2, resample on Q4; a pulse leaves once per rise
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			smp2_reg <= 1'b1; // High, so an idle-high pin shows no edge
			smp4_reg <= 1'b1;
			o_sync <= 1'b0;
		end else begin
			if (ph_reg == TMRPS_Q2) begin
				smp2_reg <= i_src; // [R15]
			end
			if (ph_reg == TMRPS_Q4) begin
				smp4_reg <= smp2_reg; // [R15]
			end
			o_sync <= (ph_reg == TMRPS_Q4) && smp2_reg && !smp4_reg;
		end
	end

	// Instruction-cycle tick for timer mode
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_q4 <= 1'b0;
		end else begin
			o_q4 <= (ph_reg == TMRPS_Q3);
		end
	end
endmodule

// ### hw/tmrps_top.sv
/*
 * Eight-bit timer sharing one prescaler with the watchdog, with option,
 * interrupt control and event registers on a plain register port.
 * Assumes a single 100 MHz clock, synchronous external clock input and a
 * master that issues one-cycle strobes and never waits.
 */
// Local design decisions: the address map and the plain strobed port.
// Contract
// R1: One prescaler serves either the timer or the watchdog, never both.
// R2: Assign bit zero gives the prescaler to the timer, else watchdog.
// R3: Three-bit ratio field picks one of eight ratios, 1:2 to 1:256.
// R4: Undivided timer counting only when the watchdog owns the prescaler.
// R5: Prescaler count is neither readable nor writable by software.
// R6: Writing the timer count clears the prescaler while timer owns it.
// R7: Watchdog clear resets watchdog and prescaler while watchdog owns it.
// R8: Timer-to-watchdog switch follows the fixed clear-assign-clear sequence.
// R9: Watchdog-to-timer switch clears first, then writes option at once.
// R10: Interrupt condition raised when the count wraps from FFh to 00h.
// R11: Overflow flag sets on every wrap regardless of the enable.
// R12: Only software clears the overflow flag, by writing zero.
// R13: Overflow forwarded as a request only while the enable is set.
// R14: Count holds during sleep, so overflow never wakes the core.
// R15: External clock sampled on Q2 and Q4 phases in counter mode.
// R16: Ratio code n divides by two to the power n plus one.
// R17: Count advances per clock-path pulse, prescaled or direct.
`timescale 1ns/100ps
`include "tmrps_map.svh"
module tmrps_top
	import tmrps_pkg::*;
#(
	parameter int WDOG_W = 16
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [`TMRPS_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_EXT_CLK,
	output logic [7:0] O_RDATA,
	output logic O_IRQ,
	output logic O_TMR_IRQ,
	output logic O_WDOG_TIMEOUT
);
	tmrps_ps_if ps_bus ();

	logic [7:0] count_reg;
	logic [7:0] option_reg;
	logic [7:0] intctl_reg;
	logic [`TMRPS_EV_W-1:0] status_reg;
	logic [`TMRPS_EV_W-1:0] enable_reg;
	logic sleep_reg;
	logic [WDOG_W-1:0] wdog_reg;
	logic ext_sync;
	logic q4_tick;
	logic [7:0] wdog_msb;
	logic wr_count, wr_option, wr_intctl, wr_clear, wr_enable, wr_ctrl;
	logic wdog_clear;
	logic owner_wdog;
	logic src_ext;
	logic edge_fall;
	logic raw_tick;
	logic timer_tick;
	logic wdog_tick;
	logic wrap;
	logic [`TMRPS_EV_W-1:0] ev_now;

	// Write decode; reads have no side effect on any state
	assign wr_count = I_WR && (I_ADDR == `TMRPS_OFS_COUNT);
	assign wr_option = I_WR && (I_ADDR == `TMRPS_OFS_OPTION);
	assign wr_intctl = I_WR && (I_ADDR == `TMRPS_OFS_INTCTL);
	assign wr_clear = I_WR && (I_ADDR == `TMRPS_OFS_CLEAR);
	assign wr_enable = I_WR && (I_ADDR == `TMRPS_OFS_ENABLE);
	assign wr_ctrl = I_WR && (I_ADDR == `TMRPS_OFS_CTRL);
	assign wdog_clear = wr_ctrl && I_WDATA[`TMRPS_CTL_WCLR];

	// Ownership and clock source selection
	assign owner_wdog = option_reg[`TMRPS_OPT_PSA]; // [R2]
	assign src_ext = option_reg[`TMRPS_OPT_SRC];
	assign edge_fall = option_reg[`TMRPS_OPT_EDGE];

	tmrps_phase u_phase (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.i_src(I_EXT_CLK ^ edge_fall),
		.o_sync(ext_sync),
		.o_q4(q4_tick)
	);

	// Timer clock path: instruction cycle or synchronised external edge
	assign raw_tick = src_ext ? ext_sync : q4_tick;

	// Prescaler is fed by exactly one owner at a time
	assign ps_bus.owner_wdog = owner_wdog;
	assign ps_bus.ratio = option_reg[`TMRPS_OPT_RATIO_MSB:`TMRPS_OPT_RATIO_LSB];
	assign ps_bus.tick_in = owner_wdog ? q4_tick : raw_tick; // [R1]
	assign ps_bus.clear = owner_wdog ? wdog_clear : wr_count; // [R6] [R7]

	tmrps_prescaler u_ps (
		.i_clk(I_CLK),
		.i_arst_n(I_ARST_N),
		.bus(ps_bus.ps)
	);

	// Direct path when the watchdog owns the prescaler
	assign timer_tick = owner_wdog ? raw_tick : ps_bus.ps_out; // [R4] [R17]
	assign wdog_tick = owner_wdog ? ps_bus.ps_out : q4_tick;

	// Wrap from all ones to zero on a counting tick
	assign wrap = timer_tick && !sleep_reg && !wr_count
		&& (count_reg == `TMRPS_CNT_ONES); // [R10]

	// Timer count: writes win over counting; frozen during sleep
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			count_reg <= `TMRPS_CNT_ZERO;
		end else if (wr_count) begin
			count_reg <= I_WDATA;
		end else if (timer_tick && !sleep_reg) begin
			count_reg <= count_reg + 8'h01; // [R14] [R17]
		end
	end

	// Option register; software sequences guard ownership changes
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			option_reg <= `TMRPS_OPT_RESET;
		end else if (wr_option) begin
			option_reg <= I_WDATA; // [R8] [R9]
		end
	end

	// Interrupt control: hardware sets the flag, software writes zero
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			intctl_reg <= `TMRPS_IC_RESET;
		end else begin
			if (wr_intctl) begin
				intctl_reg <= I_WDATA & `TMRPS_IC_MASK; // [R12]
			end
			if (wrap) begin
				intctl_reg[`TMRPS_IC_FLAG] <= 1'b1; // [R11]
			end
		end
	end

	// Sleep control, held until software releases it
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			sleep_reg <= 1'b0;
		end else if (wr_ctrl) begin
			sleep_reg <= I_WDATA[`TMRPS_CTL_SLEEP];
		end
	end

	// Watchdog count; its timeout is reported, not acted on here
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			wdog_reg <= '0;
		end else if (wdog_clear) begin
			wdog_reg <= '0; // [R7]
		end else if (wdog_tick) begin
			wdog_reg <= wdog_reg + {{(WDOG_W-1){1'b0}}, 1'b1};
		end
	end

	// Top byte of the watchdog; a narrow watchdog reads zero-extended
	if (WDOG_W >= 8) begin : g_wdog_wide
		assign wdog_msb = wdog_reg[WDOG_W-1 -: 8];
	end else begin : g_wdog_narrow
		assign wdog_msb = {{(8-WDOG_W){1'b0}}, wdog_reg};
	end

	// Sticky event bits; a set in the clear cycle survives
	assign ev_now[`TMRPS_EV_OVF] = wrap;
	assign ev_now[`TMRPS_EV_WDTO] = wdog_tick && !wdog_clear
		&& (&wdog_reg);
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg
				& ~(wr_clear ? I_WDATA[`TMRPS_EV_W-1:0] : '0)) | ev_now;
		end
	end

	// Event enables
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			enable_reg <= '0;
		end else if (wr_enable) begin
			enable_reg <= I_WDATA[`TMRPS_EV_W-1:0];
		end
	end

	// Outputs from flip-flops; the flag request needs its enable
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_IRQ <= 1'b0;
			O_TMR_IRQ <= 1'b0;
			O_WDOG_TIMEOUT <= 1'b0;
		end else begin
			O_IRQ <= |(status_reg & enable_reg);
			O_TMR_IRQ <= intctl_reg[`TMRPS_IC_FLAG]
				&& intctl_reg[`TMRPS_IC_IE]; // [R13]
			O_WDOG_TIMEOUT <= ev_now[`TMRPS_EV_WDTO];
		end
	end

	// Read data in the cycle after the strobe; prescaler has no address
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RDATA <= `TMRPS_DATA_ZERO;
		end else if (I_RD) begin
			unique case (I_ADDR)
				`TMRPS_OFS_COUNT: O_RDATA <= count_reg;
				`TMRPS_OFS_OPTION: O_RDATA <= option_reg;
				`TMRPS_OFS_INTCTL: O_RDATA <= intctl_reg;
				`TMRPS_OFS_STATUS: O_RDATA <= {6'h00, status_reg};
				`TMRPS_OFS_ENABLE: O_RDATA <= {6'h00, enable_reg};
				`TMRPS_OFS_CTRL: O_RDATA <= {7'h00, sleep_reg};
				`TMRPS_OFS_WDOG: O_RDATA <= wdog_msb;
				default: O_RDATA <= `TMRPS_DATA_ZERO; // [R5]
			endcase
		end else begin
			O_RDATA <= `TMRPS_DATA_ZERO;
		end
	end
endmodule

// ### tb/tmrps_top_sva.sv
/* Port checker for the shared-prescaler timer top.
 Assumes tmrps_map.svh is on the include path and one clock domain. */
`timescale 1ns/100ps
`include "tmrps_map.svh"
module tmrps_top_sva #(
	parameter int WDOG_W = 16
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [`TMRPS_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_EXT_CLK,
	input wire logic [7:0] O_RDATA,
	input wire logic O_IRQ,
	input wire logic O_TMR_IRQ,
	input wire logic O_WDOG_TIMEOUT
);
	logic ie_reg;
	logic en_reg;
	logic sleep_reg;
	logic wr_ic;
	logic wr_ev;
	// Write decodes; the clear and enable registers can both drop the irq
	assign wr_ic = I_WR && I_ADDR == `TMRPS_OFS_INTCTL;
	assign wr_ev = I_WR && (I_ADDR == `TMRPS_OFS_CLEAR ||
		I_ADDR == `TMRPS_OFS_ENABLE);
	// Shadows built from bus writes only, never from design state
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			ie_reg <= 1'b0;
			en_reg <= 1'b0;
			sleep_reg <= 1'b0;
		end else if (I_WR) begin
			if (I_ADDR == `TMRPS_OFS_INTCTL)
				ie_reg <= I_WDATA[`TMRPS_IC_IE];
			if (I_ADDR == `TMRPS_OFS_ENABLE)
				en_reg <= |I_WDATA[1:0];
			if (I_ADDR == `TMRPS_OFS_CTRL)
				sleep_reg <= I_WDATA[`TMRPS_CTL_SLEEP];
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	sequence s_wclr;
		I_WR && I_ADDR == `TMRPS_OFS_CTRL && I_WDATA[`TMRPS_CTL_WCLR];
	endsequence
	sequence s_quiet;
		!O_WDOG_TIMEOUT [*8];
	endsequence
	property p_rd_idle;
		!$past(I_RD) |-> O_RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read answer");
	property p_unmapped;
		I_RD && I_ADDR > 4'h7 |=> O_RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read returned data");
	property p_tmr_en;
		O_TMR_IRQ |-> $past(ie_reg);
	endproperty
	a_tmr_en: assert property (p_tmr_en)
		else $error("timer irq without enable");
	property p_irq_en;
		O_IRQ |-> $past(en_reg);
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("irq without enable");
	property p_flag_sticky;
		$fell(O_TMR_IRQ) |-> $past(wr_ic, 2);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("timer irq dropped without a write");
	property p_status_sticky;
		$fell(O_IRQ) |-> $past(wr_ev, 2);
	endproperty
	a_status_sticky: assert property (p_status_sticky)
		else $error("irq dropped without a write");
	property p_sleep_hold;
		$rose(O_TMR_IRQ) && $past(sleep_reg, 2) && $past(sleep_reg, 3)
			|-> $past(wr_ic, 2);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold)
		else $error("overflow during sleep");
	property p_wdog_pulse;
		O_WDOG_TIMEOUT |=> !O_WDOG_TIMEOUT;
	endproperty
	a_wdog_pulse: assert property (p_wdog_pulse)
		else $error("watchdog timeout longer than one cycle");
	property p_wclr;
		s_wclr |-> ##2 s_quiet;
	endproperty
	a_wclr: assert property (p_wclr)
		else $error("watchdog timeout right after a clear");
endmodule
bind tmrps_top tmrps_top_sva #(.WDOG_W(WDOG_W)) tmrps_top_sva_i (
	.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_EXT_CLK(I_EXT_CLK),
	.O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_TMR_IRQ(O_TMR_IRQ),
	.O_WDOG_TIMEOUT(O_WDOG_TIMEOUT));

// ### tb/tb_top.sv
/* Self-checking bench for the shared-prescaler timer.
 Assumes tmrps_map.svh on the include path; watchdog shortened to 4 bits. */
`timescale 1ns/100ps
`include "tmrps_map.svh"
module tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [`TMRPS_ADDR_W-1:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic ext_clk = 1'b0;
	logic [7:0] rdata;
	logic irq;
	logic tmr_irq;
	logic wdog_to;
	logic [7:0] v;
	logic [7:0] v0;
	int n;
	int error_cnt = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	tmrps_top #(.WDOG_W(4)) tmrps_top_i (.I_CLK(clk), .I_ARST_N(arst_n),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
		.I_EXT_CLK(ext_clk), .O_RDATA(rdata), .O_IRQ(irq),
		.O_TMR_IRQ(tmr_irq), .O_WDOG_TIMEOUT(wdog_to));
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// Four steps to the wrap; a stale prescaler count would skew the time
	task automatic span(input int p);
		wr(`TMRPS_OFS_INTCTL, 8'h00);
		wr(`TMRPS_OFS_COUNT, 8'hFC);
		wr(`TMRPS_OFS_INTCTL, 8'h20);
		n = 0;
		while (tmr_irq !== 1'b1 && n < 4 * p + 40) begin
			cyc(1);
			n++;
		end
		chk("wrap time", {7'h00, n >= 4*p-4 && n <= 4*p+12}, 8'h01);
		if (tmr_irq !== 1'b1)
			print_verdict();
	endtask
	// External clock pulses, eight cycles per level so each is sampled
	task automatic pulses(input int k);
		repeat (k) begin
			repeat (8) @(posedge clk);
			ext_clk <= 1'b1;
			repeat (8) @(posedge clk);
			ext_clk <= 1'b0;
		end
		cyc(20);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rd(`TMRPS_OFS_OPTION, v);
		chk("option reset", v, `TMRPS_OPT_RESET);
		rd(`TMRPS_OFS_INTCTL, v);
		chk("intctl reset", v, `TMRPS_IC_RESET);
		for (int a = 8; a < 16; a++) begin
			rd(4'(a), v);
			chk("unmapped", v, 8'h00);
		end
		// Hand the prescaler to the timer, then every ratio code
		wr(`TMRPS_OFS_CTRL, 8'h02);
		for (int r = 0; r < 8; r++) begin
			wr(`TMRPS_OFS_OPTION, 8'(r));
			span(4 << (r + 1));
		end
		// Back to the watchdog in the safe order; timer then undivided
		wr(`TMRPS_OFS_CTRL, 8'h02);
		wr(`TMRPS_OFS_COUNT, 8'h00);
		wr(`TMRPS_OFS_OPTION, 8'h0F);
		wr(`TMRPS_OFS_CTRL, 8'h02);
		wr(`TMRPS_OFS_OPTION, 8'h08);
		span(4);
		// Flag sets with the enable off and stays until software clears it
		wr(`TMRPS_OFS_INTCTL, 8'h00);
		wr(`TMRPS_OFS_COUNT, 8'hFE);
		cyc(30);
		rd(`TMRPS_OFS_INTCTL, v);
		chk("flag no enable", v, 8'h04);
		chk("timer irq masked", {7'h00, tmr_irq}, 8'h00);
		cyc(200);
		rd(`TMRPS_OFS_INTCTL, v);
		chk("flag sticky", v, 8'h04);
		wr(`TMRPS_OFS_INTCTL, 8'h00);
		rd(`TMRPS_OFS_INTCTL, v);
		chk("flag cleared", v, 8'h00);
		// Clears faster than the watchdog wraps keep it from timing out
		wr(`TMRPS_OFS_CTRL, 8'h02);
		wr(`TMRPS_OFS_CLEAR, 8'h02);
		repeat (30) begin
			wr(`TMRPS_OFS_CTRL, 8'h02);
			cyc(4);
		end
		rd(`TMRPS_OFS_STATUS, v);
		chk("no timeout", v & 8'h02, 8'h00);
		n = 0;
		while (wdog_to !== 1'b1 && n < 20000) begin
			cyc(1);
			n++;
		end
		chk("timeout", {7'h00, wdog_to}, 8'h01);
		if (wdog_to !== 1'b1)
			print_verdict();
		// Sleep freezes the count; interrupt masking and clearing
		wr(`TMRPS_OFS_CTRL, 8'h01);
		rd(`TMRPS_OFS_COUNT, v0);
		cyc(60);
		rd(`TMRPS_OFS_COUNT, v);
		chk("sleep count", v, v0);
		wr(`TMRPS_OFS_INTCTL, 8'h24);
		cyc(2);
		chk("irq in sleep", {7'h00, tmr_irq}, 8'h01);
		wr(`TMRPS_OFS_INTCTL, 8'h00);
		wr(`TMRPS_OFS_STATUS, 8'h00);
		rd(`TMRPS_OFS_STATUS, v);
		chk("status read only", v & 8'h01, 8'h01);
		wr(`TMRPS_OFS_ENABLE, 8'h01);
		cyc(2);
		chk("irq on", {7'h00, irq}, 8'h01);
		wr(`TMRPS_OFS_ENABLE, 8'h00);
		cyc(2);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wr(`TMRPS_OFS_ENABLE, 8'h01);
		wr(`TMRPS_OFS_CLEAR, 8'h01);
		cyc(2);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		// Counter mode: five rising, then three falling edges, undivided
		wr(`TMRPS_OFS_CTRL, 8'h00);
		wr(`TMRPS_OFS_OPTION, 8'h28);
		wr(`TMRPS_OFS_COUNT, 8'h00);
		pulses(5);
		rd(`TMRPS_OFS_COUNT, v);
		chk("external count", v, 8'h05);
		wr(`TMRPS_OFS_OPTION, 8'h38);
		cyc(16);
		wr(`TMRPS_OFS_COUNT, 8'h00);
		pulses(3);
		rd(`TMRPS_OFS_COUNT, v);
		chk("external fall count", v, 8'h03);
		print_verdict();
	end
endmodule
